//--- inc/lnsw_pkg.sv
// package: constants, offsets and types of the link node status word bank
package lnsw_pkg;
    // data and storage shape
    localparam int LNSW_APB_DW = 32;
    localparam int LNSW_AW = 12;
    localparam int LNSW_WORD_W = 16;
    localparam int LNSW_NUM_WORDS = 12;
    localparam int LNSW_SLOT_W = 4;
    localparam int LNSW_NODES = 32;
    localparam int LNSW_GRP = 8;
    localparam int LNSW_LVL_UNITS = 16;
    // register indices in the system flag area; byte address is four times the index
    localparam logic [7:0] LNSW_IDX_CTRL = 8'h00;
    localparam logic [7:0] LNSW_IDX_IRQ_STAT = 8'h01;
    localparam logic [7:0] LNSW_IDX_IRQ_MASK = 8'h02;
    localparam logic [7:0] LNSW_IDX_NET_L0_1_8 = 8'hEE;
    localparam logic [7:0] LNSW_IDX_NET_L0_9_16 = 8'hEF;
    localparam logic [7:0] LNSW_IDX_NET_L0_17_24 = 8'hF0;
    localparam logic [7:0] LNSW_IDX_NET_L0_25_32 = 8'hF1;
    localparam logic [7:0] LNSW_IDX_NET_L1_1_8 = 8'hF2;
    localparam logic [7:0] LNSW_IDX_NET_L1_9_16 = 8'hF3;
    localparam logic [7:0] LNSW_IDX_NET_L1_17_24 = 8'hF4;
    localparam logic [7:0] LNSW_IDX_NET_L1_25_32 = 8'hF5;
    localparam logic [7:0] LNSW_IDX_LU_WORD_A = 8'hF7;
    localparam logic [7:0] LNSW_IDX_LU_WORD_B = 8'hF8;
    localparam logic [7:0] LNSW_IDX_LU_WORD_C = 8'hF9;
    localparam logic [7:0] LNSW_IDX_LU_WORD_D = 8'hFA;
    // storage slots: net level 0 at 0..3, net level 1 at 4..7, link unit words a..d at 8..11
    localparam logic [3:0] LNSW_SLOT_NET_L0 = 4'h0;
    localparam logic [3:0] LNSW_SLOT_NET_L1 = 4'h4;
    localparam logic [3:0] LNSW_SLOT_LU = 4'h8;
    localparam logic [3:0] LNSW_SLOT_LAST = 4'hB;
    // control fields
    localparam int LNSW_CTRL_FREEZE_BIT = 0;
    localparam int LNSW_CTRL_TWO_LEVEL_BIT = 1;
    localparam logic [1:0] LNSW_CTRL_RST = 2'h0;
    // interrupt status / mask fields
    localparam int LNSW_IRQ_W = 5;
    localparam int LNSW_IRQ_NET_L0_CHG = 0;
    localparam int LNSW_IRQ_NET_L1_CHG = 1;
    localparam int LNSW_IRQ_LU_L0_CHG = 2;
    localparam int LNSW_IRQ_LU_L1_CHG = 3;
    localparam int LNSW_IRQ_LU_ERR = 4;
    localparam logic [4:0] LNSW_IRQ_RST = 5'h00;
    // scanner state
    typedef enum logic [1:0] {
        LNSW_ST_SCAN = 2'b01,
        LNSW_ST_HOLD = 2'b10
    } lnsw_scan_t;
endpackage

//--- inc/lnsw_mem_if.sv
// interface: write and read ports of the status word store
`timescale 1ns/1ps
interface lnsw_mem_if #(
    parameter int DW = 16,
    parameter int SW = 4
);
    logic wr_en;
    logic [SW-1:0] wr_slot;
    logic [DW-1:0] wr_data;
    logic [SW-1:0] rd_slot;
    logic [DW-1:0] rd_data;
    modport ctrl (output wr_en, output wr_slot, output wr_data, output rd_slot, input rd_data);
    modport mem (input wr_en, input wr_slot, input wr_data, input rd_slot, output rd_data);
endinterface

//--- verilog/lnsw_mem.sv
// module: small status word store with registered read data
`timescale 1ns/1ps
module lnsw_mem #(
    parameter int DEPTH = 12,
    parameter int DW = 16,
    parameter int SW = 4
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // store ports
    lnsw_mem_if.mem mp
);
    logic [DW-1:0] mem_q [DEPTH];
    logic [DW-1:0] rd_q;

    // write port; all words clear at reset so nothing reads as stale
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else if (mp.wr_en && (int'(mp.wr_slot) < DEPTH)) begin
            mem_q[mp.wr_slot] <= mp.wr_data;
        end
    end

    // read port, one cycle latency; slots beyond depth read zero
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rd_q <= '0;
        end else if (int'(mp.rd_slot) < DEPTH) begin
            rd_q <= mem_q[mp.rd_slot];
        end else begin
            rd_q <= '0;
        end
    end

    assign mp.rd_data = rd_q;
endmodule

//--- verilog/lnsw_top.sv
// module: link node status word bank, apb slave and interrupt logic
`timescale 1ns/1ps
module lnsw_top
    import lnsw_pkg::*;
(
    // clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_RST_N,
    // apb slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [LNSW_AW-1:0] I_PADDR,
    input wire logic [LNSW_APB_DW-1:0] I_PWDATA,
    input wire logic [3:0] I_PSTRB,
    output logic [LNSW_APB_DW-1:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    // first network node flags, node n at bit n-1
    input wire logic [LNSW_NODES-1:0] I_NET_L0_ERR,
    input wire logic [LNSW_NODES-1:0] I_NET_L0_RUN,
    input wire logic [LNSW_NODES-1:0] I_NET_L1_ERR,
    input wire logic [LNSW_NODES-1:0] I_NET_L1_RUN,
    // link unit flags; two level: level 0 at 15:0, level 1 at 31:16
    input wire logic [LNSW_NODES-1:0] I_LU_RUN,
    input wire logic [LNSW_NODES-1:0] I_LU_ERR,
    // interrupt
    output logic O_IRQ
);
    localparam int RAW_W = 6 * LNSW_NODES;

    // synchroniser and change detect flops
    logic [RAW_W-1:0] sync1_q;
    logic [RAW_W-1:0] sync2_q;
    logic [RAW_W-1:0] prev_q;
    // control, interrupt and bus flops
    logic [1:0] ctrl_q;
    logic [LNSW_IRQ_W-1:0] irq_stat_q;
    logic [LNSW_IRQ_W-1:0] irq_stat_d;
    logic [LNSW_IRQ_W-1:0] irq_mask_q;
    logic ready_q;
    logic [LNSW_APB_DW-1:0] prdata_q;
    lnsw_scan_t scan_st_q;
    lnsw_scan_t scan_st_d;
    logic [LNSW_SLOT_W-1:0] scan_slot_q;
    logic [LNSW_SLOT_W-1:0] scan_slot_d;

    lnsw_mem_if #(.DW(LNSW_WORD_W), .SW(LNSW_SLOT_W)) mem_bus ();

    lnsw_mem #(
        .DEPTH(LNSW_NUM_WORDS),
        .DW(LNSW_WORD_W),
        .SW(LNSW_SLOT_W)
    ) u_mem (
        .i_clk(I_CLK_SYS),
        .i_rst_n(I_RST_N),
        .mp(mem_bus.mem)
    );

    // map a register index to its storage slot; valid tells whether it is a status word
    function automatic logic [4:0] idx_to_slot(input logic [7:0] idx);
        logic [4:0] r;
        r = 5'h00;
        if ((idx >= LNSW_IDX_NET_L0_1_8) && (idx <= LNSW_IDX_NET_L1_25_32)) begin
            r = {1'b1, 4'(idx - LNSW_IDX_NET_L0_1_8)};
        end else if ((idx >= LNSW_IDX_LU_WORD_A) && (idx <= LNSW_IDX_LU_WORD_D)) begin
            r = {1'b1, 4'(LNSW_SLOT_LU + 4'(idx - LNSW_IDX_LU_WORD_A))};
        end
        return r;
    endfunction

    // first network word: low byte error flags, high byte run flags of one eight-node group
    function automatic logic [15:0] net_word(
        input logic [LNSW_NODES-1:0] err,
        input logic [LNSW_NODES-1:0] run,
        input logic [1:0] grp
    );
        logic [15:0] w;
        w = {run[grp*LNSW_GRP +: LNSW_GRP], err[grp*LNSW_GRP +: LNSW_GRP]};
        return w;
    endfunction

    // link unit word: run flags low, error flags high; group 0 is word d
    function automatic logic [15:0] lu_word(
        input logic [LNSW_NODES-1:0] run,
        input logic [LNSW_NODES-1:0] err,
        input logic [1:0] grp
    );
        logic [15:0] w;
        w = {err[grp*LNSW_GRP +: LNSW_GRP], run[grp*LNSW_GRP +: LNSW_GRP]};
        return w;
    endfunction

    // synced views of the pins
    logic [LNSW_NODES-1:0] s_net_l0_err;
    logic [LNSW_NODES-1:0] s_net_l0_run;
    logic [LNSW_NODES-1:0] s_net_l1_err;
    logic [LNSW_NODES-1:0] s_net_l1_run;
    logic [LNSW_NODES-1:0] s_lu_run;
    logic [LNSW_NODES-1:0] s_lu_err;
    logic [LNSW_NODES-1:0] p_net_l0_err;
    logic [LNSW_NODES-1:0] p_net_l0_run;
    logic [LNSW_NODES-1:0] p_net_l1_err;
    logic [LNSW_NODES-1:0] p_net_l1_run;
    logic [LNSW_NODES-1:0] p_lu_run;
    logic [LNSW_NODES-1:0] p_lu_err;
    assign {s_net_l0_err, s_net_l0_run, s_net_l1_err, s_net_l1_run, s_lu_run, s_lu_err} = sync2_q;
    assign {p_net_l0_err, p_net_l0_run, p_net_l1_err, p_net_l1_run, p_lu_run, p_lu_err} = prev_q;

    // pins come from the link hardware's own timing, so two flops before any use
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q <= '0;
        end else begin
            sync1_q <= {I_NET_L0_ERR, I_NET_L0_RUN, I_NET_L1_ERR, I_NET_L1_RUN,
                        I_LU_RUN, I_LU_ERR};
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // word selection for the slot being refreshed
    logic [1:0] scan_grp;
    logic [15:0] scan_word;
    assign scan_grp = scan_slot_q[1:0];
    // single and two level share one layout: word d = units 0-7 (level 0 units 0-7),
    // c = 8-15 (level 0 8-15), b = 16-23 (level 1 0-7), a = 24-31 (level 1 8-15)
    assign scan_word = (scan_slot_q < LNSW_SLOT_NET_L1) ?
                           net_word(s_net_l0_err, s_net_l0_run, scan_grp) :
                       (scan_slot_q < LNSW_SLOT_LU) ?
                           net_word(s_net_l1_err, s_net_l1_run, scan_grp) :
                           lu_word(s_lu_run, s_lu_err, 2'(3 - int'(scan_grp)));

    // scanner: refreshes one status word per cycle, all twelve in twelve cycles;
    // a freeze holds a consistent snapshot for software at the cost of staleness
    always_comb begin
        scan_st_d = scan_st_q;
        scan_slot_d = scan_slot_q;
        case (scan_st_q)
            LNSW_ST_SCAN: begin
                scan_slot_d = (scan_slot_q == LNSW_SLOT_LAST) ? '0 : scan_slot_q + 4'h1;
                if (ctrl_q[LNSW_CTRL_FREEZE_BIT] && (scan_slot_q == LNSW_SLOT_LAST)) begin
                    scan_st_d = LNSW_ST_HOLD;
                end
            end
            LNSW_ST_HOLD: begin
                scan_slot_d = '0;
                if (!ctrl_q[LNSW_CTRL_FREEZE_BIT]) begin
                    scan_st_d = LNSW_ST_SCAN;
                end
            end
            default: begin
                scan_st_d = LNSW_ST_SCAN;
                scan_slot_d = '0;
            end
        endcase
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            scan_st_q <= LNSW_ST_SCAN;
            scan_slot_q <= '0;
        end else begin
            scan_st_q <= scan_st_d;
            scan_slot_q <= scan_slot_d;
        end
    end

    // store write port is owned by the scanner only, so the bus cannot alter the flags
    assign mem_bus.wr_en = (scan_st_q == LNSW_ST_SCAN);
    assign mem_bus.wr_slot = scan_slot_q;
    assign mem_bus.wr_data = scan_word;

    // apb decode
    logic [7:0] acc_idx;
    logic [4:0] acc_slot;
    logic acc_is_word;
    logic acc_is_ctrl;
    logic acc_is_stat;
    logic acc_is_mask;
    logic acc_mapped;
    logic acc_done;
    logic wr_done;
    assign acc_idx = I_PADDR[9:2];
    assign acc_slot = idx_to_slot(acc_idx);
    assign acc_is_word = acc_slot[4] && (I_PADDR[LNSW_AW-1:10] == '0);
    assign acc_is_ctrl = (I_PADDR[LNSW_AW-1:2] == {2'h0, LNSW_IDX_CTRL});
    assign acc_is_stat = (I_PADDR[LNSW_AW-1:2] == {2'h0, LNSW_IDX_IRQ_STAT});
    assign acc_is_mask = (I_PADDR[LNSW_AW-1:2] == {2'h0, LNSW_IDX_IRQ_MASK});
    assign acc_mapped = acc_is_word || acc_is_ctrl || acc_is_stat || acc_is_mask;
    assign acc_done = I_PSEL && I_PENABLE && ready_q;
    assign wr_done = acc_done && I_PWRITE && I_PSTRB[0] && acc_mapped;
    assign mem_bus.rd_slot = acc_slot[3:0];

    // one wait state: the store read lands during the first access cycle
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= I_PSEL && I_PENABLE && !ready_q;
        end
    end

    // read data register, loaded in the wait cycle and held to the end of the access
    logic [LNSW_APB_DW-1:0] own_rd;
    assign own_rd = acc_is_ctrl ? {30'h0, ctrl_q} :
                    acc_is_stat ? {27'h0, irq_stat_q} :
                    acc_is_mask ? {27'h0, irq_mask_q} : 32'h0;

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            prdata_q <= '0;
        end else if (I_PSEL && I_PENABLE && !ready_q && !I_PWRITE) begin
            prdata_q <= acc_is_word ? {16'h0, mem_bus.rd_data} : own_rd;
        end
    end

    // control register: freeze and arrangement; status word writes are dropped
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            ctrl_q <= LNSW_CTRL_RST;
        end else if (wr_done && acc_is_ctrl) begin
            ctrl_q <= I_PWDATA[1:0];
        end
    end

    // events; in single level all link units count as level 0 changes
    logic two_level;
    logic [LNSW_IRQ_W-1:0] evt;
    logic lu_lo_chg;
    logic lu_hi_chg;
    assign two_level = ctrl_q[LNSW_CTRL_TWO_LEVEL_BIT];
    assign lu_lo_chg = (s_lu_run[LNSW_LVL_UNITS-1:0] != p_lu_run[LNSW_LVL_UNITS-1:0]);
    assign lu_hi_chg = (s_lu_run[LNSW_NODES-1:LNSW_LVL_UNITS] !=
                        p_lu_run[LNSW_NODES-1:LNSW_LVL_UNITS]);
    assign evt[LNSW_IRQ_NET_L0_CHG] = ({s_net_l0_err, s_net_l0_run} !=
                                       {p_net_l0_err, p_net_l0_run});
    assign evt[LNSW_IRQ_NET_L1_CHG] = ({s_net_l1_err, s_net_l1_run} !=
                                       {p_net_l1_err, p_net_l1_run});
    assign evt[LNSW_IRQ_LU_L0_CHG] = lu_lo_chg || (!two_level && lu_hi_chg);
    assign evt[LNSW_IRQ_LU_L1_CHG] = two_level && lu_hi_chg;
    assign evt[LNSW_IRQ_LU_ERR] = |(s_lu_err & ~p_lu_err);

    // sticky status, write one to clear; a new event in the clear cycle wins
    always_comb begin
        irq_stat_d = irq_stat_q;
        if (wr_done && acc_is_stat) begin
            irq_stat_d = irq_stat_d & ~I_PWDATA[LNSW_IRQ_W-1:0];
        end
        irq_stat_d = irq_stat_d | evt;
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            irq_stat_q <= LNSW_IRQ_RST;
            irq_mask_q <= LNSW_IRQ_RST;
        end else begin
            irq_stat_q <= irq_stat_d;
            if (wr_done && acc_is_mask) begin
                irq_mask_q <= I_PWDATA[LNSW_IRQ_W-1:0];
            end
        end
    end

    // bus and interrupt outputs
    assign O_PRDATA = prdata_q;
    assign O_PREADY = ready_q;
    assign O_PSLVERR = acc_done && !acc_mapped;
    assign O_IRQ = |(irq_stat_q & irq_mask_q);
endmodule

//--- tb/lnsw_link_units.sv
// partner model: remote link units presenting run and error flags
`timescale 1ns/1ps
module lnsw_link_units (
    // control from the bench
    input wire logic i_clk,
    input wire logic i_upd,
    input wire logic i_slow,
    input wire logic [191:0] i_flags,
    // flags towards the bank
    output logic [191:0] o_flags
);
    logic [2:0] step_q;
    initial begin
        o_flags = '0;
        step_q = 3'h6;
    end
    // slow units settle one 32-bit group a cycle, so the bank sees a ragged change
    always @(posedge i_clk) begin
        if (i_upd) begin
            step_q <= i_slow ? 3'h0 : 3'h6;
            if (!i_slow) o_flags <= i_flags;
        end else if (step_q < 3'h6) begin
            o_flags[32*step_q +: 32] <= i_flags[32*step_q +: 32];
            step_q <= step_q + 3'h1;
        end
    end
endmodule

//--- tb/lnsw_top_monitor.sv
// checker: bus timing and status word contents at the bank's ports
`timescale 1ns/1ps
module lnsw_top_monitor
    import lnsw_pkg::*;
(
    // clock, reset and bus
    input wire logic I_CLK_SYS,
    input wire logic I_RST_N,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [LNSW_AW-1:0] I_PADDR,
    input wire logic [LNSW_APB_DW-1:0] I_PWDATA,
    input wire logic [3:0] I_PSTRB,
    input wire logic [LNSW_APB_DW-1:0] O_PRDATA,
    input wire logic O_PREADY,
    input wire logic O_PSLVERR,
    // link flags and interrupt
    input wire logic [LNSW_NODES-1:0] I_NET_L0_ERR,
    input wire logic [LNSW_NODES-1:0] I_NET_L0_RUN,
    input wire logic [LNSW_NODES-1:0] I_NET_L1_ERR,
    input wire logic [LNSW_NODES-1:0] I_NET_L1_RUN,
    input wire logic [LNSW_NODES-1:0] I_LU_RUN,
    input wire logic [LNSW_NODES-1:0] I_LU_ERR,
    input wire logic O_IRQ
);
    logic [191:0] flags;
    logic [191:0] flags_q;
    logic [4:0] stab_q;
    logic [7:0] idx;
    logic [1:0] grp;
    logic [1:0] unit;
    logic mapped;
    logic rd_ok;
    logic frz_q;
    // decode; reads are judged only once sync and scanner have settled
    assign flags = {I_NET_L0_ERR, I_NET_L0_RUN, I_NET_L1_ERR, I_NET_L1_RUN, I_LU_RUN, I_LU_ERR};
    assign idx = I_PADDR[9:2];
    assign grp = idx[1:0] + 2'h2;
    assign unit = 2'h2 - idx[1:0];
    assign mapped = I_PADDR[11:10] == 2'h0 && (idx <= 8'h02 || (idx >= 8'hEE && idx <= 8'hFA
        && idx != 8'hF6));
    assign rd_ok = O_PREADY && !I_PWRITE && mapped && !frz_q && stab_q == 5'h1F;
    // cycles since any link flag moved or a freeze ended, saturating;
    // a frozen bank shows stale words on purpose, so those reads are not judged
    always_ff @(posedge I_CLK_SYS) begin
        flags_q <= flags;
        if (!I_RST_N) frz_q <= 1'b0;
        else if (O_PREADY && I_PWRITE && I_PSTRB[0] && I_PADDR == 12'h000) frz_q <= I_PWDATA[0];
        if (!I_RST_N || flags != flags_q || frz_q) stab_q <= 5'h00;
        else if (stab_q != 5'h1F) stab_q <= stab_q + 5'h01;
    end
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RST_N);
    reset_quiet_a: assert property ($rose(I_RST_N) |-> !O_IRQ && !O_PREADY)
        else $error("outputs active after reset");
    ready_one_wait_a: assert property (I_PSEL && !I_PENABLE |=> !O_PREADY ##1 O_PREADY)
        else $error("ready not in second access cycle");
    ready_pulse_a: assert property (O_PREADY |=> !O_PREADY)
        else $error("ready longer than one cycle");
    ready_in_access_a: assert property (O_PREADY |-> I_PSEL && I_PENABLE)
        else $error("ready outside access phase");
    error_map_a: assert property (O_PREADY |-> O_PSLVERR == !mapped)
        else $error("error flag disagrees with address map");
    unmapped_zero_a: assert property (O_PREADY && !I_PWRITE && !mapped |-> O_PRDATA == 0)
        else $error("unmapped read not zero");
    upper_zero_a: assert property (O_PREADY && !I_PWRITE && idx >= 8'hEE |-> O_PRDATA[31:16] == 0)
        else $error("status word upper half not zero");
    net_word_a: assert property (rd_ok && idx >= 8'hEE && idx <= 8'hF5 |->
        O_PRDATA[15:0] == (idx >= 8'hF2 ? {I_NET_L1_RUN[{grp, 3'h0} +: 8], I_NET_L1_ERR[{grp, 3'h0} +: 8]}
        : {I_NET_L0_RUN[{grp, 3'h0} +: 8], I_NET_L0_ERR[{grp, 3'h0} +: 8]}))
        else $error("network status word wrong");
    unit_word_a: assert property (rd_ok && idx >= 8'hF7 && idx <= 8'hFA |->
        O_PRDATA[15:0] == {I_LU_ERR[{unit, 3'h0} +: 8], I_LU_RUN[{unit, 3'h0} +: 8]})
        else $error("link unit status word wrong");
endmodule
bind lnsw_top lnsw_top_monitor u_lnsw_top_monitor (.I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N),
    .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
    .I_PWDATA(I_PWDATA), .I_PSTRB(I_PSTRB),
    .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
    .I_NET_L0_ERR(I_NET_L0_ERR), .I_NET_L0_RUN(I_NET_L0_RUN), .I_NET_L1_ERR(I_NET_L1_ERR),
    .I_NET_L1_RUN(I_NET_L1_RUN), .I_LU_RUN(I_LU_RUN), .I_LU_ERR(I_LU_ERR), .O_IRQ(O_IRQ));

//--- tb/lnsw_tb_top.sv
// testbench: status word bank against a behavioural model
`timescale 1ns/1ps
`define CHK(g, e, m) begin n_compared++; if ((g) !== (e)) begin err_total++; \
    $display("CHECK FAILED t=%0t %s", $time, m); end end
module lnsw_tb_top;
    import lnsw_pkg::*;
    logic clk, rst_n, psel, pen, pwr, upd, slow;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic pready, pslverr, irq;
    logic [191:0] want, lnk, old;
    logic [31:0] rd;
    logic er;
    int err_total = 0;
    int n_compared = 0;
    logic [7:0] words[$] = '{8'hEE, 8'hEF, 8'hF0, 8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF5,
        8'hF7, 8'hF8, 8'hF9, 8'hFA};
    logic [11:0] bad[$] = '{12'h3D8, 12'h3B4, 12'h00C, 12'h7E8};
    lnsw_top u_lnsw_top (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .I_NET_L0_ERR(lnk[191:160]),
        .I_NET_L0_RUN(lnk[159:128]), .I_NET_L1_ERR(lnk[127:96]), .I_NET_L1_RUN(lnk[95:64]),
        .I_LU_RUN(lnk[63:32]), .I_LU_ERR(lnk[31:0]), .O_IRQ(irq));
    lnsw_link_units u_lnsw_link_units (.i_clk(clk), .i_upd(upd), .i_slow(slow), .i_flags(want),
        .o_flags(lnk));
    // model of one status word from the flags handed to the link units
    function automatic logic [31:0] exp_word(input logic [7:0] i, input logic [191:0] f);
        int g;
        int k;
        g = (i - 8'hEE) % 4;
        k = 8'hFA - i;
        if (i <= 8'hF1) return {16'h0000, f[128+8*g +: 8], f[160+8*g +: 8]};
        if (i <= 8'hF5) return {16'h0000, f[64+8*g +: 8], f[96+8*g +: 8]};
        return {16'h0000, f[8*k +: 8], f[32+8*k +: 8]};
    endfunction
    // one bus transfer, held until ready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    // hand new flags to the units and let the bank settle
    task automatic load(input logic [191:0] f, input logic s);
        want = f;
        @(posedge clk);
        upd <= 1'b1;
        slow <= s;
        @(posedge clk);
        upd <= 1'b0;
        repeat (40) @(posedge clk);
    endtask
    task automatic chk_words();
        foreach (words[i]) begin
            apb(1'b0, {2'h0, words[i], 2'h0}, 32'h0, 4'h0);
            `CHK(rd, exp_word(words[i], want), "status word")
            `CHK(er, 1'b0, "error on status word")
        end
    endtask
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        #(100 * 30000);
        err_total++;
        complete_run();
    end
    initial begin
        {rst_n, psel, pen, pwr, upd, slow, paddr, pwdata, pstrb} = '0;
        want = '0;
        void'($urandom(33));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        chk_words();
        apb(1'b0, 12'h000, 32'h0, 4'h0);
        `CHK(rd, 32'h0, "control reset")
        apb(1'b0, 12'h008, 32'h0, 4'h0);
        `CHK(rd, 32'h0, "mask reset")
        $display("reset values done");
        for (int r = 0; r < 6; r++) begin
            load(r == 0 ? '1 : {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom}, r[0]);
            if (r == 3) apb(1'b1, 12'h000, 32'h2, 4'hF);
            apb(1'b1, {2'h0, words[r*2], 2'h0}, $urandom, 4'hF);
            `CHK(er, 1'b0, "write to status word refused")
            chk_words();
        end
        // freeze: a finished sweep is held while the link flags move on
        old = want;
        apb(1'b1, 12'h000, 32'h3, 4'hF);
        repeat (20) @(posedge clk);
        load(~old, 1'b0);
        foreach (words[i]) begin
            apb(1'b0, {2'h0, words[i], 2'h0}, 32'h0, 4'h0);
            `CHK(rd, exp_word(words[i], old), "frozen status word")
        end
        apb(1'b1, 12'h000, 32'h2, 4'hF);
        repeat (20) @(posedge clk);
        chk_words();
        $display("freeze done");
        apb(1'b1, 12'h000, 32'h3, 4'h0);
        apb(1'b0, 12'h000, 32'h0, 4'h0);
        `CHK(rd, 32'h2, "two level arrangement setting")
        $display("status words done");
        foreach (bad[i]) begin
            apb(1'b1, bad[i], 32'hFFFF, 4'hF);
            `CHK(er, 1'b1, "unmapped write")
            apb(1'b0, bad[i], 32'h0, 4'h0);
            `CHK({er, rd}, {1'b1, 32'h0}, "unmapped read")
        end
        $display("unmapped done");
        load('0, 1'b0);
        apb(1'b1, 12'h008, 32'h1F, 4'hF);
        apb(1'b1, 12'h004, 32'h1F, 4'hF);
        // irq is registered, so it is looked at once the completing edge has settled
        @(negedge clk);
        `CHK(irq, 1'b0, "irq after clear")
        load(192'h8, 1'b1);
        apb(1'b0, 12'h004, 32'h0, 4'h0);
        `CHK(rd, 32'h10, "error event status")
        @(negedge clk);
        `CHK(irq, 1'b1, "irq raised")
        apb(1'b1, 12'h008, 32'h0, 4'hF);
        @(negedge clk);
        `CHK(irq, 1'b0, "irq masked")
        apb(1'b1, 12'h004, 32'h1F, 4'hF);
        load(192'h8 | (192'h1 << 96), 1'b0);
        apb(1'b0, 12'h004, 32'h0, 4'h0);
        `CHK(rd, 32'h2, "level one network event")
        apb(1'b1, 12'h008, 32'h2, 4'hF);
        @(negedge clk);
        `CHK(irq, 1'b1, "irq unmasked")
        apb(1'b1, 12'h004, 32'h2, 4'hF);
        @(negedge clk);
        `CHK(irq, 1'b0, "irq cleared")
        // a run change of unit 16 counts as level 1 only in the two level arrangement
        load(192'h8 | (192'h1 << 96) | (192'h1 << 48), 1'b0);
        apb(1'b0, 12'h004, 32'h0, 4'h0);
        `CHK(rd, 32'h8, "two level unit run event")
        apb(1'b1, 12'h000, 32'h0, 4'hF);
        apb(1'b1, 12'h004, 32'h1F, 4'hF);
        load(192'h8 | (192'h1 << 96), 1'b0);
        apb(1'b0, 12'h004, 32'h0, 4'h0);
        `CHK(rd, 32'h4, "single level unit run event")
        $display("interrupt done");
        complete_run();
    end
endmodule
